// ==== hw/mce_pkg.sv ====
// package for the memory-check error block: register map, field positions,
// reset values and the syndrome table of the 64+8 bit secded code.
// assumes a 32-bit classic wishbone register bus and one system clock.
package mce_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets on the wishbone bus
    localparam logic [7:0] MCE_OFS_CTRL = 8'h00;   // check control
    localparam logic [7:0] MCE_OFS_STAT_LO = 8'h04; // error status bits 31:0
    localparam logic [7:0] MCE_OFS_STAT_HI = 8'h08; // error status bits 63:32
    localparam logic [7:0] MCE_OFS_ICLR = 8'h0c;   // interrupt source clear

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int MCE_CTRL_MODE_BIT = 2;     // 1 = ecc, 0 = byte parity
    localparam int MCE_CTRL_DIS_BIT = 3;      // 1 = checking disabled
    localparam int MCE_ICLR_CHK_BIT = 2;      // write one clears the flags
    localparam int MCE_ST_ADDR_MSB = 35;
    localparam int MCE_ST_SYN_LSB = 48;
    localparam int MCE_ST_PAR_BIT = 56;
    localparam int MCE_ST_ECC_BIT = 57;
    localparam int MCE_ST_MULTI_BIT = 58;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic MCE_RST_MODE = 1'b0;
    localparam logic MCE_RST_DIS = 1'b0;
    localparam logic [63:0] MCE_RST_STATUS = 64'h0;

    ////////////////////////////////////////////////////////////////////////////
    // syndrome of each data bit, index = data bit number
    localparam logic [7:0] MCE_DATA_SYN [0:63] = '{
        8'hce, 8'hcb, 8'hd3, 8'hd5, 8'hd6, 8'hd9, 8'hda, 8'hdc,
        8'h23, 8'h25, 8'h26, 8'h29, 8'h2a, 8'h2c, 8'h31, 8'h34,
        8'h0e, 8'h0b, 8'h13, 8'h15, 8'h16, 8'h19, 8'h1a, 8'h1c,
        8'he3, 8'he5, 8'he6, 8'he9, 8'hea, 8'hec, 8'hf1, 8'hf4,
        8'h4f, 8'h4a, 8'h52, 8'h54, 8'h57, 8'h58, 8'h5b, 8'h5d,
        8'ha2, 8'ha4, 8'ha7, 8'ha8, 8'hab, 8'had, 8'hb0, 8'hb5,
        8'h8f, 8'h8a, 8'h92, 8'h94, 8'h97, 8'h98, 8'h9b, 8'h9d,
        8'h62, 8'h64, 8'h67, 8'h68, 8'h6b, 8'h6d, 8'h70, 8'h75
    };

endpackage

// ==== hw/mce_check_gen.sv ====
// check-bit generator: eight secded check bits or eight even byte parities.
// assumes a combinational use on same-clock data; no state.
`timescale 1ns/100ps
module mce_check_gen (
    // data and mode
    input wire logic [63:0] data_in,
    input wire logic ecc_mode_in,
    // check bits
    output logic [7:0] check_out
);

    ////////////////////////////////////////////////////////////////////////////
    // column masks built from the table so a flipped data bit yields its syndrome
    logic [7:0][63:0] col_mask;
    logic [7:0] ecc_bits;
    logic [7:0] par_bits;

    genvar k, i;
    generate
        for (k = 0; k < 8; k++) begin : g_chk
            for (i = 0; i < 64; i++) begin : g_bit
                assign col_mask[k][i] = mce_pkg::MCE_DATA_SYN[i][k];
            end
            assign ecc_bits[k] = ^(data_in & col_mask[k]);
            assign par_bits[k] = ^data_in[8*k +: 8]; // even parity per byte
        end
    endgenerate

    // mode picks the code
    assign check_out = ecc_mode_in ? ecc_bits : par_bits;

endmodule

// ==== hw/mce_syn_decode.sv ====
// syndrome decoder: maps an 8-bit syndrome to the single bit in error.
// assumes the syndrome is stable within the cycle; purely combinational.
`timescale 1ns/100ps
module mce_syn_decode (
    // syndrome
    input wire logic [7:0] syn_in,
    // decode result
    output logic [63:0] flip_mask_out,
    output logic data_hit_out,
    output logic check_hit_out,
    output logic multi_out
);

    ////////////////////////////////////////////////////////////////////////////
    // one comparator per data bit, one-hot result used as correction mask
    genvar i;
    generate
        for (i = 0; i < 64; i++) begin : g_cmp
            assign flip_mask_out[i] = (syn_in == mce_pkg::MCE_DATA_SYN[i]);
        end
    endgenerate

    // a lone check bit shows as a one-hot syndrome
    assign data_hit_out = |flip_mask_out;
    assign check_hit_out = (syn_in != 8'h00) && ((syn_in & (syn_in - 8'h01)) == 8'h00);
    // nonzero and no single-bit match means uncorrectable
    assign multi_out = (syn_in != 8'h00) && !data_hit_out && !check_hit_out;

endmodule

// ==== hw/mce_top.sv ====
// memory-check error block: check generation on writes, checking and
// single-bit correction on reads, sticky error flags and error status.
// assumes read/write data comes from logic on clk_in and a classic
// wishbone master with 32-bit data reaches the registers.
`timescale 1ns/100ps
module mce_top (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // memory write path
    input wire logic wr_valid_in,
    input wire logic [63:0] wr_data_in,
    output logic [7:0] wr_check_out,
    // memory read path
    input wire logic rd_valid_in,
    input wire logic [63:0] rd_data_in,
    input wire logic [7:0] rd_check_in,
    input wire logic [35:0] rd_addr_in,
    output logic [63:0] rd_data_out,
    output logic rd_valid_out,
    output logic rd_bad_out,
    // mode levels for the rest of the controller
    output logic ecc_mode_out,
    output logic check_off_out
);

    ////////////////////////////////////////////////////////////////////////////
    // all state of the block
    typedef struct packed {
        logic mode;            // check type select
        logic dis;             // check disable
        logic s_valid;         // read stage
        logic [63:0] s_data;
        logic [7:0] s_check;
        logic [35:0] s_addr;
        logic par_flag;
        logic ecc_flag;
        logic multi_flag;
        logic [35:0] err_addr;
        logic [7:0] err_syn;
        logic [63:0] o_data;
        logic o_valid;
        logic o_bad;
        logic [7:0] wr_check;
        logic ack;
        logic [31:0] rdata;
    } mce_state_t;

    mce_state_t st_r;
    mce_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // check generation for the outgoing write and the staged read
    logic [7:0] wr_gen;
    logic [7:0] rd_gen;
    logic [7:0] syn;
    logic [63:0] flip_mask;
    logic data_hit;
    logic check_hit;
    logic multi;

    mce_check_gen u_wr_gen (
        .data_in(wr_data_in),
        .ecc_mode_in(st_r.mode),
        .check_out(wr_gen)
    );

    mce_check_gen u_rd_gen (
        .data_in(st_r.s_data),
        .ecc_mode_in(st_r.mode),
        .check_out(rd_gen)
    );

    // in parity mode this is the xored even-parity result per byte
    assign syn = st_r.s_check ^ rd_gen;

    mce_syn_decode u_dec (
        .syn_in(syn),
        .flip_mask_out(flip_mask),
        .data_hit_out(data_hit),
        .check_hit_out(check_hit),
        .multi_out(multi)
    );

    ////////////////////////////////////////////////////////////////////////////
    // status register image
    logic [63:0] status;

    always_comb begin
        status = 64'h0; // reserved bits stay zero
        status[mce_pkg::MCE_ST_ADDR_MSB:0] = st_r.err_addr;
        status[mce_pkg::MCE_ST_SYN_LSB +: 8] = st_r.err_syn;
        status[mce_pkg::MCE_ST_PAR_BIT] = st_r.par_flag;
        status[mce_pkg::MCE_ST_ECC_BIT] = st_r.ecc_flag;
        status[mce_pkg::MCE_ST_MULTI_BIT] = st_r.multi_flag;
    end

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    logic bus_req;
    logic bus_wr;
    logic clr_hit;
    logic chk_on;
    logic par_err;
    logic ecc_err;
    logic multi_err;
    logic any_err;

    always_comb begin
        st_nxt = st_r;
        // one wait state: ack the cycle after the request, drop it after
        bus_req = wb_cyc_in && wb_stb_in && !st_r.ack;
        bus_wr = bus_req && wb_we_in;
        clr_hit = bus_wr && wb_sel_in[0] && (wb_adr_in == mce_pkg::MCE_OFS_ICLR)
            && wb_dat_in[mce_pkg::MCE_ICLR_CHK_BIT];
        st_nxt.ack = bus_req;

        // control register; only byte lane 0 holds live bits
        if (bus_wr && wb_sel_in[0] && wb_adr_in == mce_pkg::MCE_OFS_CTRL) begin
            st_nxt.mode = wb_dat_in[mce_pkg::MCE_CTRL_MODE_BIT];
            st_nxt.dis = wb_dat_in[mce_pkg::MCE_CTRL_DIS_BIT];
        end

        // read data, unmapped addresses answer zero; status is read only
        if (bus_req) begin
            unique case (wb_adr_in)
                mce_pkg::MCE_OFS_CTRL: begin
                    st_nxt.rdata = 32'h0;
                    st_nxt.rdata[mce_pkg::MCE_CTRL_MODE_BIT] = st_r.mode;
                    st_nxt.rdata[mce_pkg::MCE_CTRL_DIS_BIT] = st_r.dis;
                end
                mce_pkg::MCE_OFS_STAT_LO: st_nxt.rdata = status[31:0];
                mce_pkg::MCE_OFS_STAT_HI: st_nxt.rdata = status[63:32];
                default: st_nxt.rdata = 32'h0;
            endcase
        end

        // read stage: capture the memory word
        st_nxt.s_valid = rd_valid_in;
        if (rd_valid_in) begin
            st_nxt.s_data = rd_data_in;
            st_nxt.s_check = rd_check_in;
            st_nxt.s_addr = rd_addr_in;
        end

        // error classes; disable masks them all
        chk_on = st_r.s_valid && !st_r.dis;
        par_err = chk_on && !st_r.mode && (syn != 8'h00);
        ecc_err = chk_on && st_r.mode && (syn != 8'h00);
        multi_err = ecc_err && multi;
        any_err = par_err || ecc_err;

        // correct a single data bit; a check-bit hit leaves data intact
        st_nxt.o_valid = st_r.s_valid;
        if (st_r.s_valid) begin
            st_nxt.o_data = (ecc_err && data_hit) ? (st_r.s_data ^ flip_mask) : st_r.s_data;
        end
        st_nxt.o_bad = multi_err || par_err;

        // sticky flags: a set in the clearing cycle wins
        if (clr_hit) begin
            st_nxt.par_flag = 1'b0;
            st_nxt.ecc_flag = 1'b0;
            st_nxt.multi_flag = 1'b0;
        end
        if (par_err) begin
            st_nxt.par_flag = 1'b1;
        end
        if (ecc_err) begin
            st_nxt.ecc_flag = 1'b1;
        end
        if (multi_err) begin
            st_nxt.multi_flag = 1'b1;
        end

        // most recent error wins the address and syndrome fields
        if (any_err) begin
            st_nxt.err_addr = st_r.s_addr;
            st_nxt.err_syn = syn;
        end

        // outgoing check bits, forced to zero while disabled
        if (wr_valid_in) begin
            st_nxt.wr_check = st_r.dis ? 8'h00 : wr_gen;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register, synchronous reset
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
            st_r.mode <= mce_pkg::MCE_RST_MODE;
            st_r.dis <= mce_pkg::MCE_RST_DIS;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops
    assign wb_ack_out = st_r.ack;
    assign wb_dat_out = st_r.rdata;
    assign wr_check_out = st_r.wr_check;
    assign rd_data_out = st_r.o_data;
    assign rd_valid_out = st_r.o_valid;
    assign rd_bad_out = st_r.o_bad;
    assign ecc_mode_out = st_r.mode;
    assign check_off_out = st_r.dis;

endmodule

// ==== test/mce_checker.sv ====
// port assertions for the memory-check error block.
// assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module mce_checker (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // register bus
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    // memory paths
    input wire logic wr_valid_in,
    input wire logic [7:0] wr_check_out,
    input wire logic rd_valid_in,
    input wire logic rd_valid_out,
    input wire logic rd_bad_out,
    input wire logic check_off_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait state, one-cycle ack
    AST_ACK_ONE: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("ack late");
    AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held");
    AST_ACK_CAUSE: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in)) else $error("ack unasked");
    // reserved and unmapped words read zero
    AST_RSV_HI: assert property (wb_ack_out && !wb_we_in && wb_adr_in == 8'h08 |->
        wb_dat_out[31:27] == 5'h00 && wb_dat_out[15:4] == 12'h000) else $error("reserved status set");
    AST_UNMAP: assert property (wb_ack_out && !wb_we_in && !(wb_adr_in inside {8'h00, 8'h04, 8'h08})
        |-> wb_dat_out == 32'h0) else $error("unmapped read nonzero");
    ////////////////////////////////////////////////////////////////////////////
    // read path latency and disable behaviour
    AST_RD_LAT: assert property (rd_valid_in |-> ##2 rd_valid_out) else $error("read latency");
    AST_RD_CAUSE: assert property (rd_valid_out |-> $past(rd_valid_in, 2)) else $error("stray read");
    AST_BAD_OFF: assert property (rd_bad_out |-> rd_valid_out && !check_off_out)
        else $error("bad flag misplaced");
    AST_CHK_OFF: assert property (wr_valid_in && check_off_out |=> wr_check_out == 8'h00)
        else $error("check bits not zero");
endmodule

bind mce_top mce_checker u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .wr_valid_in(wr_valid_in), .wr_check_out(wr_check_out),
    .rd_valid_in(rd_valid_in), .rd_valid_out(rd_valid_out), .rd_bad_out(rd_bad_out),
    .check_off_out(check_off_out));

// ==== test/mce_mem_model.sv ====
// sdram array model holding 16 words and their eight check bits.
// assumes check bits follow their data word by one cycle.
`timescale 1ns/100ps
module mce_mem_model (
    // clock
    input wire logic clk_in,
    // write side
    input wire logic wr_valid_in,
    input wire logic [3:0] wr_addr_in,
    input wire logic [63:0] wr_data_in,
    input wire logic [7:0] wr_check_in,
    // read request and fault injection
    input wire logic rq_in,
    input wire logic [35:0] rq_addr_in,
    input wire logic [63:0] flip_data_in,
    input wire logic [7:0] flip_check_in,
    // read return
    output logic rd_valid_out,
    output logic [63:0] rd_data_out,
    output logic [7:0] rd_check_out,
    output logic [35:0] rd_addr_out
);
    logic [63:0] mem_data [0:15];
    logic [7:0] mem_check [0:15];
    logic pend_r = 1'b0;
    logic [3:0] pend_addr_r = 4'h0;
    initial begin
        {rd_valid_out, rd_data_out, rd_check_out, rd_addr_out} = '0;
    end
    // store words; check lines land one cycle after data
    always @(posedge clk_in) begin
        pend_r <= wr_valid_in;
        pend_addr_r <= wr_addr_in;
        if (wr_valid_in) mem_data[wr_addr_in] <= wr_data_in;
        if (pend_r) mem_check[pend_addr_r] <= wr_check_in;
        rd_valid_out <= rq_in;
        if (rq_in) begin
            rd_data_out <= mem_data[rq_addr_in[3:0]] ^ flip_data_in;
            rd_check_out <= mem_check[rq_addr_in[3:0]] ^ flip_check_in;
            rd_addr_out <= rq_addr_in;
        end else begin
            // idle lines toggle so stale data never passes for a match
            rd_data_out <= ~rd_data_out;
            rd_check_out <= ~rd_check_out;
            rd_addr_out <= ~rd_addr_out;
        end
    end
endmodule

// ==== test/mce_top_tb.sv ====
// self-checking bench for the memory-check error block.
// assumes the sdram model on the memory side and a wishbone master task.
`timescale 1ns/100ps
module mce_top_tb;
    logic clk_in = 1'b0, rst_n_in = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, wv = 1'b0, rq = 1'b0;
    logic [7:0] adr = 8'h00, fc = 8'h00, wchk, mrc;
    logic [3:0] sel = 4'h0, wa = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic [63:0] wd = 64'h0, fd = 64'h0, mrd, rdo;
    logic [35:0] ra = 36'h0, mra;
    logic ack, mrv, rvo, rbo, emo, coo;
    int err_count = 0, check_count = 0, cyc_cnt = 0;
    localparam logic [63:0] syn_row [0:7] = '{64'hdcdad9d6d5d3cbce,
        64'h34312c2a29262523, 64'h1c1a191615130b0e, 64'hf4f1eceae9e6e5e3,
        64'h5d5b585754524a4f, 64'hb5b0adaba8a7a4a2, 64'h9d9b989794928a8f,
        64'h75706d6b68676462};
    mce_top u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
        .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .wr_valid_in(wv), .wr_data_in(wd), .wr_check_out(wchk), .rd_valid_in(mrv), .rd_data_in(mrd),
        .rd_check_in(mrc), .rd_addr_in(mra), .rd_data_out(rdo), .rd_valid_out(rvo), .rd_bad_out(rbo),
        .ecc_mode_out(emo), .check_off_out(coo));
    mce_mem_model u_mem (.clk_in(clk_in), .wr_valid_in(wv), .wr_addr_in(wa), .wr_data_in(wd),
        .wr_check_in(wchk), .rq_in(rq), .rq_addr_in(ra), .flip_data_in(fd), .flip_check_in(fc),
        .rd_valid_out(mrv), .rd_data_out(mrd), .rd_check_out(mrc), .rd_addr_out(mra));
    initial forever #5 clk_in = ~clk_in;
    ////////////////////////////////////////////////////////////////////////////
    // shared tasks
    // wide enough for a full data word plus its bad flag
    task automatic chk(input string name, input logic [71:0] seen, input logic [71:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_in);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
        do @(posedge clk_in); while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic st(output logic [63:0] s);
        wb(1'b0, 8'h04, 32'h0, s[31:0]);
        wb(1'b0, 8'h08, 32'h0, s[63:32]);
    endtask
    task automatic wr_word(input logic [3:0] a, input logic [63:0] d);
        @(posedge clk_in);
        {wv, wa, wd} <= {1'b1, a, d};
        @(posedge clk_in);
        wv <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rd_word(input logic [35:0] a, input logic [63:0] f, input logic [7:0] g,
        output logic [63:0] d, output logic b);
        @(posedge clk_in);
        {rq, ra, fd, fc} <= {1'b1, a, f, g};
        @(posedge clk_in);
        rq <= 1'b0;
        do @(posedge clk_in); while (rvo !== 1'b1);
        d = rdo;
        b = rbo;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        logic [31:0] q;
        wb(1'b1, 8'h10, 32'hffffffff, q);
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, 8'(i * 4), 32'h0, q);
            chk("reset word", q, 64'h0);
        end
        chk("modes", {emo, coo}, 64'h0);
        $display("t_reset done");
    endtask
    task automatic t_parity;
        logic [31:0] q;
        logic [63:0] s, d;
        logic b;
        wb(1'b1, 8'h00, 32'h0, q);
        wr_word(4'h3, 64'h0123456789abcdef);
        chk("parity bits", wchk, 64'hff);
        rd_word(36'h900000003, 64'h1 << 27, 8'h00, d, b);
        chk("parity bad", {d, b}, {64'h0123456781abcdef, 1'b1});
        st(s);
        chk("parity status", {s[58:48], s[35:0]}, {3'b001, 8'h08, 36'h900000003});
        wb(1'b1, 8'h0c, 32'h4, q);
        st(s);
        chk("cleared", {s[58:48], s[35:0]}, {3'b000, 8'h08, 36'h900000003});
        $display("t_parity done");
    endtask
    task automatic t_ecc;
        logic [31:0] q;
        logic [63:0] s, d;
        logic [7:0] e;
        logic b;
        wb(1'b1, 8'h00, 32'h4, q);
        wr_word(4'h1, 64'h0);
        chk("ecc mode", {emo, wchk}, 64'h100);
        for (int i = 0; i < 72; i++) begin
            e = (i < 64) ? syn_row[i / 8][(i % 8) * 8 +: 8] : 8'(1 << (i - 64));
            rd_word(36'(i * 16 + 1), (i < 64) ? 64'h1 << i : 64'h0, (i < 64) ? 8'h0 : e, d, b);
            chk("corrected", {d, b}, 65'h0);
            st(s);
            chk("ecc status", {s[58:48], s[35:0]}, {3'b010, e, 36'(i * 16 + 1)});
            wb(1'b1, 8'h0c, 32'h4, q);
        end
        $display("t_ecc done");
    endtask
    task automatic t_multi;
        logic [31:0] q;
        logic [63:0] s, d;
        logic b;
        // word 1 holds zero with valid ecc; two flipped bits make it uncorrectable
        rd_word(36'h11, 64'h3, 8'h00, d, b);
        chk("multi bad", b, 64'h1);
        st(s);
        chk("multi status", s[58:48], {3'b110, 8'h05});
        wb(1'b1, 8'h0c, 32'h4, q);
        rd_word(36'h1, 64'h0, 8'h00, d, b);
        st(s);
        chk("clean read", {b, s[58:56]}, 64'h0);
        $display("t_multi done");
    endtask
    task automatic t_disable;
        logic [31:0] q;
        logic [63:0] s, d;
        logic b;
        wb(1'b1, 8'h00, 32'hc, q);
        wr_word(4'h2, 64'hffff000012345678);
        chk("off bits", {coo, wchk}, 64'h100);
        rd_word(36'h2, 64'h10, 8'h01, d, b);
        chk("off read", {d, b}, {64'hffff000012345668, 1'b0});
        wb(1'b1, 8'h08, 32'hffffffff, q);
        st(s);
        chk("off status", {s[63:56], s[47:36]}, 64'h0);
        wb(1'b1, 8'h00, 32'h0, q);
        $display("t_disable done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // hang guard, well above the roughly 1100 cycles the run needs
    always @(posedge clk_in) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            err_count++;
            print_verdict;
        end
    end
    initial begin
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_reset;
        t_parity;
        t_ecc;
        t_multi;
        t_disable;
        print_verdict;
    end
endmodule
